// ---- fcbr_flash_model.sv ----
// Purpose: Behavioural flash device with busy status and chip reset
// Assumes: Busy time is four cycles per unit of the written byte
// Notes:   Released data lines show a pattern that flips every cycle
`timescale 1ns/100ps
module fcbr_flash_model #(parameter int RST_CYC = 4) (
    input  wire logic        sys_clk_in,
    input  wire logic        be0_n_in,
    input  wire logic        be1_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [18:0] addr_in,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    output logic      [18:0] lat_addr_out,
    output logic      [7:0]  lat_data_out,
    output logic      [7:0]  resets_out
);
    logic busy = 0, we_d = 1;
    logic [9:0] left = 0;
    logic [7:0] last = 0, low_n = 0;
    wire sel = !be0_n_in || !be1_n_in;
    wire all_low = sel && !oe_n_in && !we_n_in;
    // Status is driven only while selected and read
    assign dq_out = (sel && !oe_n_in) ? {busy, 7'h00} : ~last;
    initial resets_out = 0;
    always @(posedge sys_clk_in) begin
        we_d <= we_n_in;
        last <= dq_out;
        low_n <= all_low ? low_n + 1 : 0;
        if (all_low && low_n == RST_CYC) begin
            busy <= 0;
            left <= 0;
            resets_out <= resets_out + 1;
        end else if (sel && oe_n_in && we_n_in && !we_d) begin
            lat_addr_out <= addr_in;
            lat_data_out <= dq_in;
            busy <= 1;
            // Scaled busy time; long erases are not modelled
            left <= {dq_in, 2'b00};
        end else if (left != 0) left <= left - 1;
        else busy <= 0;
    end
endmodule

// ---- fcbr_host.sv ----
// Purpose: Host controller driving flash strobes, address and data bus
// Assumes: Single clock; flash data pins are sampled through two flops
// Notes:   One request at a time; busy polling ends on the ready bit or the poll timeout
`timescale 1ns/100ps
module fcbr_host
    import fcbr_pkg::*;
#(
    parameter int RESET_CYC   = RESET_HOLD_CYC,
    parameter int TIMEOUT_CYC = BYTE_WR_MAX_CYC
) (
    input  wire logic              sys_clk_in,
    input  wire logic              nrst_in,
    input  wire logic              req_valid_in,
    input  wire logic              req_write_in,
    input  wire logic              req_poll_in,
    input  wire logic              req_bank_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [7:0]        req_data_in,
    input  wire logic              chip_reset_req_in,
    input  wire logic [7:0]        flash_dq_in,
    output logic                   req_ready_out,
    output logic                   rsp_valid_out,
    output logic [7:0]             rsp_data_out,
    output logic                   rsp_timeout_out,
    output logic [ADDR_W-1:0]      flash_addr_out,
    output logic [7:0]             flash_dq_out,
    output logic                   flash_dq_oe_out,
    output logic                   bank_zero_select_n_out,
    output logic                   bank_one_select_n_out,
    output logic                   flash_oe_n_out,
    output logic                   flash_we_n_out
);
    // Refuse counts that the down-counters cannot hold. A reset hold of
    // zero would make the deliberate chip reset a single-cycle glitch,
    // which the flash would simply ignore.
    initial begin
        if (RESET_CYC < 1 || TIMEOUT_CYC < 1 || TIMEOUT_CYC >= 2**30)
            $error("fcbr_host: bad count parameter");
    end

    // Sequencer states:
    //   S_PRST/S_RHOLD/S_RREC  deliberate chip reset and its recovery
    //   S_WSET/S_WLOW/S_WREC   WE-controlled command write
    //   S_RLOW/S_RDONE         plain read of one byte
    //   S_POLL/S_PCHK          status read repeated until ready
    typedef enum logic [3:0] {
        S_IDLE, S_PRST, S_RHOLD, S_RREC, S_WSET, S_WLOW, S_WREC,
        S_RLOW, S_RDONE, S_POLL, S_PCHK
    } fcbr_state_e;

    // Sequencer state, shared down-counter and poll timeout counter.
    // One counter serves every phase, since phases never overlap.
    fcbr_state_e      state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] tmo;
    logic [7:0]       dq_meta;
    logic [7:0]       dq_sync;
    logic             cur_bank;

    // Count done and busy-flag decode shared by states
    wire cnt_done    = (cnt == '0);
    wire dev_busy    = dq_sync[STATUS_BUSY_BIT];
    wire tmo_done    = (tmo == '0);
    wire sel_zero_n  = cur_bank;
    wire sel_one_n   = ~cur_bank;

    // Two-flop capture of the asynchronous flash data pins
    always_ff @(posedge sys_clk_in) begin
        dq_meta <= flash_dq_in;
        dq_sync <= dq_meta;
    end

    // Main sequencer; OE and WE never fall together, except the chip reset, where bank zero, OE and WE fall together
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state                  <= S_PRST;
            cnt                    <= CNT_W'(SETUP_CYC);
            tmo                    <= '0;
            cur_bank               <= 1'b0;
            req_ready_out          <= 1'b0;
            rsp_valid_out          <= 1'b0;
            rsp_data_out           <= 8'h00;
            rsp_timeout_out        <= 1'b0;
            flash_addr_out         <= '0;
            flash_dq_out           <= 8'h00;
            flash_dq_oe_out        <= 1'b0;
            bank_zero_select_n_out <= 1'b1;
            bank_one_select_n_out  <= 1'b1;
            flash_oe_n_out         <= 1'b1;
            flash_we_n_out         <= 1'b1;
        end else begin
            rsp_valid_out <= 1'b0;
            if (!cnt_done)
                cnt <= cnt - 1'b1;
            case (state)
                S_IDLE: begin
                    if (chip_reset_req_in) begin
                        req_ready_out <= 1'b0;
                        cnt   <= CNT_W'(SETUP_CYC);
                        state <= S_PRST;
                    end else if (req_valid_in && req_ready_out) begin
                        req_ready_out  <= 1'b0;
                        cur_bank       <= req_bank_in;
                        flash_addr_out <= req_addr_in;
                        flash_dq_out   <= req_data_in;
                        cnt            <= CNT_W'(SETUP_CYC);
                        if (req_write_in) begin
                            flash_dq_oe_out <= 1'b1;
                            state           <= S_WSET;
                        end else begin
                            tmo   <= CNT_W'(TIMEOUT_CYC);
                            state <= req_poll_in ? S_POLL : S_RLOW;
                        end
                    end else begin
                        req_ready_out <= 1'b1;
                    end
                end
                // Deliberate reset: bank zero, OE and WE low together
                S_PRST: if (cnt_done) begin
                    flash_dq_oe_out        <= 1'b0;
                    bank_zero_select_n_out <= 1'b0;
                    flash_oe_n_out         <= 1'b0;
                    flash_we_n_out         <= 1'b0;
                    cnt   <= CNT_W'(RESET_CYC);
                    state <= S_RHOLD;
                end
                S_RHOLD: if (cnt_done) begin
                    bank_zero_select_n_out <= 1'b1;
                    flash_oe_n_out         <= 1'b1;
                    flash_we_n_out         <= 1'b1;
                    cnt   <= CNT_W'(WR_REC_CYC);
                    state <= S_RREC;
                end
                S_RREC: if (cnt_done)
                    state <= S_IDLE;
                // Bank strobe and WE fall together, WE rises first as the controlling edge
                S_WSET: if (cnt_done) begin
                    bank_zero_select_n_out <= sel_zero_n;
                    bank_one_select_n_out  <= sel_one_n;
                    flash_we_n_out         <= 1'b0;
                    cnt   <= CNT_W'(WR_PULSE_CYC);
                    state <= S_WLOW;
                end
                // Address and data stay until recovery ends
                S_WLOW: if (cnt_done) begin
                    flash_we_n_out <= 1'b1;
                    cnt   <= CNT_W'(WR_REC_CYC);
                    state <= S_WREC;
                end
                S_WREC: begin
                    // Bank rises a cycle after WE to keep the hold.
                    // The recovery count also covers the WE high time,
                    // so back-to-back writes never shorten that pulse.
                    bank_zero_select_n_out <= 1'b1;
                    bank_one_select_n_out  <= 1'b1;
                    if (cnt_done) begin
                        flash_dq_oe_out <= 1'b0;
                        rsp_valid_out   <= 1'b1;
                        state           <= S_IDLE;
                    end
                end
                // Plain read or status poll: select and OE low together
                S_RLOW, S_POLL: if (cnt_done) begin
                    bank_zero_select_n_out <= sel_zero_n;
                    bank_one_select_n_out  <= sel_one_n;
                    flash_oe_n_out         <= 1'b0;
                    cnt   <= CNT_W'(RD_ACC_CYC + 2);    // Two for sync flops
                    state <= (state == S_POLL) ? S_PCHK : S_RDONE;
                end
                S_RDONE: if (cnt_done) begin
                    bank_zero_select_n_out <= 1'b1;
                    bank_one_select_n_out  <= 1'b1;
                    flash_oe_n_out         <= 1'b1;
                    rsp_data_out  <= dq_sync;
                    rsp_valid_out <= 1'b1;
                    state         <= S_IDLE;
                end
                // Poll until busy clears; timeout flags a stuck write
                S_PCHK: begin
                    if (!tmo_done)
                        tmo <= tmo - 1'b1;
                    if (cnt_done) begin
                        bank_zero_select_n_out <= 1'b1;
                        bank_one_select_n_out  <= 1'b1;
                        flash_oe_n_out         <= 1'b1;
                        if (!dev_busy || tmo_done) begin
                            rsp_data_out    <= dq_sync;
                            rsp_timeout_out <= dev_busy;
                            rsp_valid_out   <= 1'b1;
                            state           <= S_IDLE;
                        end else begin
                            cnt   <= CNT_W'(WR_REC_CYC);
                            state <= S_POLL;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// ---- fcbr_host_chk.sv ----
// Purpose: Strobe protocol checks on the flash host controller pins
// Assumes: One clock domain, strobes active low
// Notes:   A run counter covers the long all-low reset hold
`timescale 1ns/100ps
module fcbr_host_chk
    import fcbr_pkg::*;
#(parameter int RESET_CYC = 4) (
    input wire logic              sys_clk_in,
    input wire logic              nrst_in,
    input wire logic              req_valid_in,
    input wire logic              chip_reset_req_in,
    input wire logic              req_ready_out,
    input wire logic              rsp_valid_out,
    input wire logic [ADDR_W-1:0] flash_addr_out,
    input wire logic [7:0]        flash_dq_out,
    input wire logic              bank_zero_select_n_out,
    input wire logic              bank_one_select_n_out,
    input wire logic              flash_oe_n_out,
    input wire logic              flash_we_n_out
);
    logic [CNT_W-1:0] low_run;
    wire sel = !bank_zero_select_n_out || !bank_one_select_n_out;
    wire tri_low = sel && !flash_oe_n_out && !flash_we_n_out;
    wire we = flash_we_n_out;
    // Length of the current all-low stretch, zero outside it
    always_ff @(posedge sys_clk_in) begin
        low_run <= (!nrst_in || !tri_low) ? '0 : low_run + 1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_one_bank; !(!bank_zero_select_n_out && !bank_one_select_n_out);
    endproperty
    a_one_bank: assert property (p_one_bank) else $error("two banks");
    property p_tri_idle; tri_low |-> !req_ready_out; endproperty
    a_tri_idle: assert property (p_tri_idle) else $error("stray low");
    property p_rst_len; $fell(tri_low) |-> low_run >= RESET_CYC; endproperty
    a_rst_len: assert property (p_rst_len) else $error("short reset");
    property p_power; $rose(nrst_in) |-> sel == 0 && flash_oe_n_out; endproperty
    a_power: assert property (p_power) else $error("strobes low");
    property p_por; $rose(nrst_in) |-> ##[1:6] tri_low; endproperty
    a_por: assert property (p_por) else $error("no power-on reset");
    property p_we_stable; !we && $past(!we) && flash_oe_n_out
        |-> $stable(flash_addr_out) && $stable(flash_dq_out); endproperty
    a_we_stable: assert property (p_we_stable) else $error("moved");
    // Only a write edge counts; the end of a chip reset raises all at once
    property p_bank_hold; $rose(we) && $past(flash_oe_n_out) |-> sel;
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("no hold");
    property p_we_width; $fell(we) && flash_oe_n_out |-> !we [*8]; endproperty
    a_we_width: assert property (p_we_width) else $error("narrow");
    property p_take; req_valid_in && req_ready_out && !chip_reset_req_in
        |=> !req_ready_out ##1 !rsp_valid_out [*8]; endproperty
    a_take: assert property (p_take) else $error("ready stuck");
    c_write: cover property ($rose(we) && flash_oe_n_out);
    c_read: cover property ($fell(flash_oe_n_out) && we);
    c_reset: cover property ($fell(tri_low));
endmodule

// ---- fcbr_host_tb.sv ----
// Purpose: Self-checking bench for the flash host controller
// Assumes: Inputs change on the falling clock edge
// Notes:   Reset hold and poll timeout are shortened by parameters
`timescale 1ns/100ps
module fcbr_host_tb;
    import fcbr_pkg::*;
    logic sys_clk_in = 0, nrst_in = 0, req_valid_in = 0, req_write_in = 0;
    logic req_poll_in = 0, req_bank_in = 0, chip_reset_req_in = 0;
    logic [ADDR_W-1:0] req_addr_in = 0, flash_addr_out, lat_a;
    logic [7:0] req_data_in = 0, flash_dq_in, rsp_data_out, flash_dq_out;
    logic [7:0] lat_d, resets;
    logic req_ready_out, rsp_valid_out, rsp_timeout_out, flash_dq_oe_out;
    logic bank_zero_select_n_out, bank_one_select_n_out;
    logic flash_oe_n_out, flash_we_n_out;
    int n_errors = 0, comparisons = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    fcbr_host #(.RESET_CYC(4), .TIMEOUT_CYC(400)) uut (.*);
    fcbr_flash_model dev (.sys_clk_in, .be0_n_in(bank_zero_select_n_out),
        .be1_n_in(bank_one_select_n_out), .oe_n_in(flash_oe_n_out),
        .we_n_in(flash_we_n_out), .addr_in(flash_addr_out),
        .dq_in(flash_dq_out), .dq_out(flash_dq_in), .lat_addr_out(lat_a),
        .lat_data_out(lat_d), .resets_out(resets));
    task automatic chk(input string nm, input logic [18:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // One request, then wait a bounded time for its response
    task automatic req(input logic w, p, b, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready_out !== 1'b1) @(negedge sys_clk_in);
        {req_write_in, req_poll_in, req_bank_in} = {w, p, b};
        req_data_in = d;
        req_addr_in = {11'h5A3, d};
        req_valid_in = 1;
        @(negedge sys_clk_in);
        req_valid_in = 0;
        while (rsp_valid_out !== 1'b1 && n < 2000) begin
            @(negedge sys_clk_in);
            n++;
        end
        chk("response", 1, n < 2000);
    endtask
    task automatic t_write(input logic b, input logic [7:0] d);
        req(1, 0, b, d);
        chk("latched addr", {11'h5A3, d}, lat_a);
        chk("latched data", d, lat_d);
        chk("dq released", 0, flash_dq_oe_out);
    endtask
    task automatic t_poll(input logic bsy);
        req(0, 1, 0, 8'h00);
        chk("ready bit", bsy, rsp_data_out[7]);
        chk("timeout", bsy, rsp_timeout_out);
    endtask
    // Request is only seen in idle, so wait for ready and hold one edge
    task automatic t_chip_reset;
        while (req_ready_out !== 1'b1) @(negedge sys_clk_in);
        chip_reset_req_in = 1;
        @(negedge sys_clk_in);
        chip_reset_req_in = 0;
        req(0, 0, 0, 8'h00);
        chk("reset count", 2, resets);
        chk("status", 0, rsp_data_out);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge sys_clk_in);
        nrst_in = 1;
        while (req_ready_out !== 1'b1) @(negedge sys_clk_in);
        chk("power-on reset", 1, resets);
        t_write(0, 8'h20);
        req(0, 0, 0, 8'h00);
        chk("busy bit", 1, rsp_data_out[7]);
        t_poll(0);
        t_write(1, 8'h10);
        t_write(1, 8'h11);
        t_poll(0);
        t_write(0, 8'hFF);
        t_poll(1);
        t_chip_reset();
        print_verdict();
    end
    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end
endmodule
bind fcbr_host fcbr_host_chk #(.RESET_CYC(RESET_CYC)) chk_i (.*);

// ---- fcbr_pkg.sv ----
// Purpose: Shared constants for the flash command bus host controller
// Assumes: 200 MHz system clock, byte-wide flash with two bank strobes
// Notes:   Times are kept in their printed unit; cycle counts derive here
package fcbr_pkg;
    localparam int CLK_MHZ            = 200;
    // Chip reset hold: strobes low longer than this time
    localparam int RESET_HOLD_US      = 5;
    localparam int RESET_HOLD_CYC     = RESET_HOLD_US * CLK_MHZ + 1;
    // Command write strobe low width and high recovery, in ns
    localparam int WR_PULSE_NS        = 110;
    localparam int WR_PULSE_CYC       = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_HIGH_NS         = 75;
    localparam int WR_HIGH_CYC        = (WR_HIGH_NS * CLK_MHZ + 999) / 1000;
    // Setup of address and data ahead of strobe fall
    localparam int SETUP_NS           = 10;
    localparam int SETUP_CYC          = (SETUP_NS * CLK_MHZ + 999) / 1000;
    // Write recovery before read and read access time, in ns
    localparam int WR_REC_NS          = 120;
    localparam int WR_REC_CYC         = (WR_REC_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_ACC_NS          = 190;
    localparam int RD_ACC_CYC         = (RD_ACC_NS * CLK_MHZ + 999) / 1000;
    // Byte write completion ceiling for the poll timeout
    localparam int BYTE_WR_MAX_US     = 250;
    localparam int BYTE_WR_MAX_CYC    = BYTE_WR_MAX_US * CLK_MHZ;
    // Busy flag position in the device status register
    localparam int STATUS_BUSY_BIT    = 7;
    localparam int ADDR_W             = 19;
    localparam int CNT_W              = 32;
endpackage
